// File: rtl/ams_alert_mask.sv
/*
 * Alert masking and single-channel select block with an AXI4-Lite
 * register slave. Holds measurement config 2, channel select, two alert
 * masks, a control register and two status readback words, and drives
 * the shared alert / fan drive pin.
 * Assumes status inputs, fan drive and detect inputs come from logic on
 * aclk; the shared pin is resolved outside from out and oe.
 */
`timescale 1ns/100ps

module ams_alert_mask (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ams_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ams_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] group_one_status,
   input wire logic high_supply_fault,
   input wire logic voltage_id_bit_five_change,
   input wire logic overtemp_fault,
   input wire logic [2:0] fan_fault,
   input wire logic fourth_tacho_fault,
   input wire logic thermal_timer_limit,
   input wire logic gpio_asserted,
   input wire logic [1:0] diode_fault,
   input wire logic overtemp_limit_mask_src,
   input wire logic [2:0] fan_detect,
   input wire logic fan_drive,
   output logic single_channel_mode,
   output logic [2:0] channel_select,
   output logic alert_n,
   output logic shared_pin_out,
   output logic shared_pin_oe
);

   // Register storage
   logic [7:0] meas_config_2_reg;
   logic [7:0] chan_select_reg;
   logic [7:0] alert_mask_1_reg;
   logic [7:0] alert_mask_2_reg;
   logic [7:0] control_reg;

   // Write channel holding state
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg;

   // Write decode
   logic [7:0] aw_idx;
   logic [7:0] w_idx;
   logic do_write;
   logic wr_en;
   logic wr_cfg2;
   logic wr_chsel;
   logic wr_mask1;
   logic wr_mask2;
   logic wr_ctl;
   logic wr_known;
   logic cfg2_locked;
   logic [7:0] cfg2_next;
   logic [7:0] mask2_next;
   logic [7:0] control_next;

   // Read decode
   logic [7:0] ar_idx;
   logic rd_take;
   logic rd_known;
   logic [7:0] rd_byte;

   // Status and alert
   logic [1:0] pin14_mode;
   logic pin21_vid;
   logic group_two_low;
   logic group_two_high;
   logic [7:0] group_two_status;
   logic [7:0] mask2_effective;
   logic [7:0] mask2_readback;
   logic [7:0] cfg2_readback;
   logic req_one;
   logic req_two;
   logic alert_any;

   // Index from byte address; low two address bits are ignored
   assign aw_idx = s_axi_awaddr[ams_pkg::IDX_LSB +: 8];
   assign ar_idx = s_axi_araddr[ams_pkg::IDX_LSB +: 8];

   // Write fires once both halves are held and no answer is pending
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign w_idx = aw_idx_reg;
   assign wr_en = do_write & w_lane_reg;
   assign wr_cfg2 = wr_en & (w_idx == ams_pkg::IDX_MEAS_CONFIG_2);
   assign wr_chsel = wr_en & (w_idx == ams_pkg::IDX_CHAN_SELECT);
   assign wr_mask1 = wr_en & (w_idx == ams_pkg::IDX_ALERT_MASK_1);
   assign wr_mask2 = wr_en & (w_idx == ams_pkg::IDX_ALERT_MASK_2);
   assign wr_ctl = wr_en & (w_idx == ams_pkg::IDX_CONTROL);
   assign wr_known = (w_idx == ams_pkg::IDX_MEAS_CONFIG_2)
      | (w_idx == ams_pkg::IDX_CHAN_SELECT)
      | (w_idx == ams_pkg::IDX_ALERT_MASK_1)
      | (w_idx == ams_pkg::IDX_ALERT_MASK_2)
      | (w_idx == ams_pkg::IDX_CONTROL)
      | (w_idx == ams_pkg::IDX_STATUS_1)
      | (w_idx == ams_pkg::IDX_STATUS_2);

   // Lock freezes config 2; the write still answers OKAY but is dropped
   assign cfg2_locked = control_reg[ams_pkg::CTL_LOCK];
   // Reserved bit 7 stores what the host writes back; detect bits are live
   assign cfg2_next = w_data_reg;
   // Overtemperature mask bit is never taken from the bus
   assign mask2_next = {w_data_reg[7:2], 1'b0, w_data_reg[0]};
   // Lock is sticky: software can set it but only reset clears it
   assign control_next = {w_data_reg[7:2], w_data_reg[1] | control_reg[ams_pkg::CTL_LOCK],
      w_data_reg[0]};

   // Field views of the control register
   assign pin14_mode = control_reg[ams_pkg::CTL_PIN14_MSB:ams_pkg::CTL_PIN14_LSB];
   assign pin21_vid = control_reg[ams_pkg::CTL_PIN21_VID];

   // Group two bit 0 follows the pin 21 function
   assign group_two_low = pin21_vid ? voltage_id_bit_five_change
      : high_supply_fault;
   // Group two bit 5 follows the pin 14 function; a reserved code is silent
   assign group_two_high = (pin14_mode == ams_pkg::PIN14_TACHO) ? fourth_tacho_fault
      : (pin14_mode == ams_pkg::PIN14_THERMAL) ? thermal_timer_limit
      : (pin14_mode == ams_pkg::PIN14_GPIO) ? gpio_asserted
      : 1'b0;
   assign group_two_status = {diode_fault, group_two_high, fan_fault, overtemp_fault,
      group_two_low};

   // Read-only overtemperature mask bit comes from the thermal logic
   assign mask2_readback = {alert_mask_2_reg[7:2], overtemp_limit_mask_src,
      alert_mask_2_reg[0]};
   // Mask 1 bit 7 covers every group two source at once
   assign mask2_effective = mask2_readback
      | {8{alert_mask_1_reg[ams_pkg::MASK1_SECOND_GROUP]}};

   assign cfg2_readback = {meas_config_2_reg[7:4], fan_detect, meas_config_2_reg[0]};

   // Group one: per-bit masks, bit positions match the source order
   ams_alert_group #(
      .WIDTH(8)
   ) u_group_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .status(group_one_status),
      .mask(alert_mask_1_reg),
      .request(req_one)
   );

   // Group two, pin-function dependent sources already steered in
   ams_alert_group #(
      .WIDTH(8)
   ) u_group_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .status(group_two_status),
      .mask(mask2_effective),
      .request(req_two)
   );

   assign alert_any = req_one | req_two;

   // Read decode; status words show raw conditions, masks do not touch them
   assign rd_take = s_axi_arvalid & s_axi_arready;
   assign rd_known = (ar_idx == ams_pkg::IDX_MEAS_CONFIG_2)
      | (ar_idx == ams_pkg::IDX_CHAN_SELECT)
      | (ar_idx == ams_pkg::IDX_ALERT_MASK_1)
      | (ar_idx == ams_pkg::IDX_ALERT_MASK_2)
      | (ar_idx == ams_pkg::IDX_CONTROL)
      | (ar_idx == ams_pkg::IDX_STATUS_1)
      | (ar_idx == ams_pkg::IDX_STATUS_2);
   assign rd_byte = (ar_idx == ams_pkg::IDX_MEAS_CONFIG_2) ? cfg2_readback
      : (ar_idx == ams_pkg::IDX_CHAN_SELECT) ? chan_select_reg
      : (ar_idx == ams_pkg::IDX_ALERT_MASK_1) ? alert_mask_1_reg
      : (ar_idx == ams_pkg::IDX_ALERT_MASK_2) ? mask2_readback
      : (ar_idx == ams_pkg::IDX_CONTROL) ? control_reg
      : (ar_idx == ams_pkg::IDX_STATUS_1) ? group_one_status
      : (ar_idx == ams_pkg::IDX_STATUS_2) ? group_two_status
      : 8'h00;

   // Write address channel: one address held until the write completes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid & s_axi_awready)
      begin
         aw_held_reg <= 1'b1;
         aw_idx_reg <= aw_idx;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
         aw_held_reg <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel, independent of the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid & s_axi_wready)
      begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0]; // Only the low lane carries a register
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_bvalid & s_axi_bready)
      begin
         w_held_reg <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   // Write response; unmapped index answers SLVERR
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ams_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? ams_pkg::RESP_OKAY : ams_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Config 2 and channel select
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meas_config_2_reg <= ams_pkg::RST_MEAS_CONFIG_2;
         chan_select_reg <= ams_pkg::RST_CHAN_SELECT;
      end
      else
      begin
         if (wr_cfg2 & ~cfg2_locked)
            meas_config_2_reg <= cfg2_next;
         if (wr_chsel)
            chan_select_reg <= w_data_reg;
      end
   end

   // Mask and control registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alert_mask_1_reg <= ams_pkg::RST_ALERT_MASK_1;
         alert_mask_2_reg <= ams_pkg::RST_ALERT_MASK_2;
         control_reg <= ams_pkg::RST_CONTROL;
      end
      else
      begin
         if (wr_mask1)
            alert_mask_1_reg <= w_data_reg;
         if (wr_mask2)
            alert_mask_2_reg <= mask2_next;
         if (wr_ctl)
            control_reg <= control_next;
      end
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ams_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_known ? ams_pkg::RESP_OKAY : ams_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // Converter controls; the sequencer reads these as plain levels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         single_channel_mode <= 1'b0;
         channel_select <= 3'h0;
      end
      else
      begin
         single_channel_mode <= meas_config_2_reg[ams_pkg::CFG2_SINGLE_CHANNEL_MODE];
         channel_select <= chan_select_reg[ams_pkg::CHSEL_MSB:ams_pkg::CHSEL_LSB];
      end
   end

   // Shared pin: open-drain alert pulls low only, fan drive is push-pull
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alert_n <= 1'b1;
         shared_pin_out <= 1'b0;
         shared_pin_oe <= 1'b0;
      end
      else
      begin
         alert_n <= ~alert_any;
         if (control_reg[ams_pkg::CTL_ALERT_SELECT])
         begin
            shared_pin_out <= 1'b0;
            shared_pin_oe <= alert_any;
         end
         else
         begin
            shared_pin_out <= fan_drive;
            shared_pin_oe <= 1'b1;
         end
      end
   end

endmodule : ams_alert_mask

// File: rtl/ams_pkg.sv
/*
 * Constants for the alert mask and channel select block: register
 * indices, field positions, reset values and bus answers.
 * Assumes an AXI4-Lite master with 32-bit data; each 8-bit register
 * sits in the low byte of one word at byte address four times its index.
 */
package ams_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CHAN_SELECT = 8'h55;
   localparam logic [7:0] IDX_CONTROL = 8'h40;
   localparam logic [7:0] IDX_MEAS_CONFIG_2 = 8'h73;
   localparam logic [7:0] IDX_ALERT_MASK_1 = 8'h74;
   localparam logic [7:0] IDX_ALERT_MASK_2 = 8'h75;
   localparam logic [7:0] IDX_STATUS_1 = 8'h41;
   localparam logic [7:0] IDX_STATUS_2 = 8'h42;

   localparam int ADDR_W = 10;
   localparam int IDX_LSB = 2;

   // Reset values
   localparam logic [7:0] RST_MEAS_CONFIG_2 = 8'h00;
   localparam logic [7:0] RST_ALERT_MASK_1 = 8'h00;
   localparam logic [7:0] RST_ALERT_MASK_2 = 8'h00;
   localparam logic [7:0] RST_CHAN_SELECT = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;

   // Measurement config 2 fields
   localparam int CFG2_SINGLE_CHANNEL_MODE = 6;
   localparam int CFG2_DETECT_LSB = 1;
   localparam int CFG2_DETECT_MSB = 3;

   // Channel select field, register 0x55
   localparam int CHSEL_LSB = 5;
   localparam int CHSEL_MSB = 7;

   // Control register fields
   localparam int CTL_ALERT_SELECT = 0;
   localparam int CTL_LOCK = 1;
   localparam int CTL_PIN21_VID = 2;
   localparam int CTL_PIN14_LSB = 3;
   localparam int CTL_PIN14_MSB = 4;

   // Shared pin 14 functions
   localparam logic [1:0] PIN14_TACHO = 2'h0;
   localparam logic [1:0] PIN14_THERMAL = 2'h1;
   localparam logic [1:0] PIN14_GPIO = 2'h2;

   // Alert mask 1 fields
   localparam int MASK1_SECOND_GROUP = 7;

   // Alert mask 2 fields
   localparam int MASK2_HIGH_SUPPLY_OR_VID = 0;
   localparam int MASK2_OVERTEMP = 1;
   localparam int MASK2_SHARED_PIN_EVENT = 5;

   // AXI answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ams_pkg

// File: rtl/ams_alert_group.sv
/*
 * One group of alert sources gated by its mask, answered as a single
 * registered request line.
 * Assumes status and mask come from logic on the same clock.
 */
`timescale 1ns/100ps

module ams_alert_group #(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] status,
   input wire logic [WIDTH-1:0] mask,
   output logic request
);

   logic request_next;

   // Only unmasked sources count; the status itself is never altered
   assign request_next = |(status & ~mask);

   // Registered so the pin sees a clean level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         request <= 1'b0;
      else
         request <= request_next;
   end

endmodule : ams_alert_group

// File: tb/ams_host.sv
/* Host model: AXI4-Lite master tasks for the alert mask block.
   Assumes one clock shared with the block. */
`timescale 1ns/100ps
module ams_host (
   input wire logic aclk,
   output logic [9:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [9:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus from time zero
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end

   // Each channel drops only at the edge that takes it
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready)
      begin
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 1'b0;
            r = s_axi_bresp;
         end
         @(posedge aclk);
      end
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_arvalid || s_axi_rready)
      begin
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            s_axi_rready <= 1'b0;
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
         end
         @(posedge aclk);
      end
   endtask : rd
endmodule : ams_host

// File: tb/ams_alert_mask_asserts.sv
/* Checker for the alert mask block: bus answers, alert cause, pin.
   Bound to the block; sees its ports only. */
`timescale 1ns/100ps
module ams_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] group_one_status,
   input wire logic high_supply_fault,
   input wire logic voltage_id_bit_five_change,
   input wire logic overtemp_fault,
   input wire logic [2:0] fan_fault,
   input wire logic fourth_tacho_fault,
   input wire logic thermal_timer_limit,
   input wire logic gpio_asserted,
   input wire logic [1:0] diode_fault,
   input wire logic fan_drive,
   input wire logic single_channel_mode,
   input wire logic [2:0] channel_select,
   input wire logic alert_n,
   input wire logic shared_pin_out,
   input wire logic shared_pin_oe
);
   // Any raw condition; masks can only narrow this set
   wire logic any_src = |{group_one_status, high_supply_fault, voltage_id_bit_five_change,
      overtemp_fault, fan_fault, fourth_tacho_fault, thermal_timer_limit, gpio_asserted,
      diode_fault};

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_quiet_no_alert: assert property (!any_src [*3] |-> alert_n)
      else $error("alert with no source");
   a_alert_has_cause: assert property (!alert_n |-> $past(any_src, 2))
      else $error("alert without earlier source");
   a_fan_pin_path: assert property (
      shared_pin_oe && alert_n |-> shared_pin_out == $past(fan_drive))
      else $error("fan drive not on pin");
   a_pin_released: assert property (!shared_pin_oe |-> alert_n && !shared_pin_out)
      else $error("pin released while alert");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   // Host never stalls the answer, so check the edge that ends it
   a_write_release: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write answer not released");
   // New read data may differ from the last, so only its shape is checked
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read answer late");
   a_mode_on_write: assert property (!$stable({single_channel_mode, channel_select})
      |-> $past(s_axi_bvalid))
      else $error("channel changed without write");
endmodule : ams_checker

bind ams_alert_mask ams_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .group_one_status,
   .high_supply_fault, .voltage_id_bit_five_change, .overtemp_fault, .fan_fault,
   .fourth_tacho_fault, .thermal_timer_limit, .gpio_asserted, .diode_fault, .fan_drive,
   .single_channel_mode, .channel_select, .alert_n, .shared_pin_out, .shared_pin_oe);

// File: tb/alert_mask_and_channel_select_test.sv
/* Bench for the alert mask block: masks, channel select, lock, bus
   errors and pin modes. Assumes the host model and bound checker. */
`timescale 1ns/100ps
module alert_mask_and_channel_select_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] group_one_status = 8'h00;
   logic [7:0] rv;
   logic [10:0] src = 11'h000; // Group two sources, one bit each
   logic ovm = 1'b0;
   logic fan_drive = 1'b0;
   logic [2:0] det = 3'h5; // Fan detect pattern read in config 2
   logic single_channel_mode, alert_n, shared_pin_out, shared_pin_oe;
   logic [2:0] channel_select;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;

   always #2.5 aclk = ~aclk;

   ams_alert_mask i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .group_one_status,
      .high_supply_fault(src[0]), .voltage_id_bit_five_change(src[1]),
      .overtemp_fault(src[2]), .fan_fault(src[5:3]), .fourth_tacho_fault(src[6]),
      .thermal_timer_limit(src[7]), .gpio_asserted(src[8]), .diode_fault(src[10:9]),
      .overtemp_limit_mask_src(ovm), .fan_detect(det), .fan_drive, .single_channel_mode,
      .channel_select, .alert_n, .shared_pin_out, .shared_pin_oe);

   ams_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // Hang guard; the full run needs a few hundred cycles
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Alert path is two registers; the third edge makes it safe to look
   task automatic alert_is(input logic exp);
      repeat (3) @(posedge aclk);
      chk("alert_n", {7'h0, exp}, {7'h0, alert_n});
      chk("pin_oe", {7'h0, ~exp}, {7'h0, shared_pin_oe});
   endtask : alert_is

   task automatic t_reset;
      i_host.rd(ams_pkg::IDX_MEAS_CONFIG_2, rv, rr);
      chk("config2", {4'h0, det, 1'b0}, rv);
      i_host.rd(ams_pkg::IDX_ALERT_MASK_1, rv, rr);
      chk("mask1", 8'h00, rv);
      chk("single", 8'h00, {7'h0, single_channel_mode});
      chk("alert_n", 8'h01, {7'h0, alert_n});
      $display("reset test done");
   endtask : t_reset

   task automatic t_mask1;
      i_host.wr(ams_pkg::IDX_CONTROL, 8'h01, rr);
      for (int i = 0; i < 7; i++)
      begin
         group_one_status <= 8'h01 << i;
         alert_is(1'b0);
         i_host.wr(ams_pkg::IDX_ALERT_MASK_1, 8'h01 << i, rr);
         alert_is(1'b1);
         i_host.rd(ams_pkg::IDX_STATUS_1, rv, rr);
         chk("status1", 8'h01 << i, rv);
         group_one_status <= 8'h00;
         i_host.wr(ams_pkg::IDX_ALERT_MASK_1, 8'h00, rr);
      end
      src <= 11'h008;
      alert_is(1'b0);
      i_host.wr(ams_pkg::IDX_ALERT_MASK_1, 8'h80, rr);
      alert_is(1'b1);
      src <= 11'h000;
      i_host.wr(ams_pkg::IDX_ALERT_MASK_1, 8'h00, rr);
      $display("mask1 test done");
   endtask : t_mask1

   // Control value, source bit and mask bit for each group two case
   task automatic t_mask2;
      logic [7:0] ctl [10] = '{8'h01, 8'h05, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h11,
         8'h01, 8'h01};
      int sb [10] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10};
      int mb [10] = '{0, 0, 2, 3, 4, 5, 5, 5, 6, 7};
      for (int k = 0; k < 10; k++)
      begin
         i_host.wr(ams_pkg::IDX_CONTROL, ctl[k], rr);
         src <= 11'h001 << sb[k];
         alert_is(1'b0);
         i_host.wr(ams_pkg::IDX_ALERT_MASK_2, 8'h01 << mb[k], rr);
         alert_is(1'b1);
         i_host.rd(ams_pkg::IDX_STATUS_2, rv, rr);
         chk("status2", 8'h01 << mb[k], rv);
         src <= 11'h000;
         i_host.wr(ams_pkg::IDX_ALERT_MASK_2, 8'h00, rr);
      end
      // Unused pin 14 code steers no source into bit 5
      i_host.wr(ams_pkg::IDX_CONTROL, 8'h19, rr);
      src <= 11'h040;
      alert_is(1'b1);
      ovm <= 1'b1;
      src <= 11'h004;
      alert_is(1'b1);
      i_host.rd(ams_pkg::IDX_ALERT_MASK_2, rv, rr);
      chk("mask2", 8'h02, rv);
      // A bus write of the read-only bit must not mask the fault
      ovm <= 1'b0;
      i_host.wr(ams_pkg::IDX_ALERT_MASK_2, 8'h02, rr);
      alert_is(1'b0);
      i_host.rd(ams_pkg::IDX_ALERT_MASK_2, rv, rr);
      chk("mask2", 8'h00, rv);
      src <= 11'h000;
      $display("mask2 test done");
   endtask : t_mask2

   // Reserved top bit is written back as read
   task automatic t_chan;
      i_host.rd(ams_pkg::IDX_MEAS_CONFIG_2, rv, rr);
      i_host.wr(ams_pkg::IDX_MEAS_CONFIG_2, {rv[7], 7'h40}, rr);
      for (int c = 0; c < 8; c++)
      begin
         i_host.wr(ams_pkg::IDX_CHAN_SELECT, {c[2:0], 5'h00}, rr);
         chk("channel", {5'h0, c[2:0]}, {5'h0, channel_select});
         chk("single", 8'h01, {7'h0, single_channel_mode});
      end
      $display("channel test done");
   endtask : t_chan

   task automatic t_lock;
      i_host.wr(ams_pkg::IDX_CONTROL, 8'h03, rr);
      i_host.wr(ams_pkg::IDX_MEAS_CONFIG_2, 8'h00, rr);
      i_host.rd(ams_pkg::IDX_MEAS_CONFIG_2, rv, rr);
      chk("config2", {4'h4, det, 1'b0}, rv);
      chk("single", 8'h01, {7'h0, single_channel_mode});
      i_host.wr(8'h10, 8'h5a, rr);
      chk("bresp", {6'h0, ams_pkg::RESP_SLVERR}, {6'h0, rr});
      i_host.rd(8'h10, rv, rr);
      chk("rresp", {6'h0, ams_pkg::RESP_SLVERR}, {6'h0, rr});
      $display("lock test done");
   endtask : t_lock

   task automatic t_fan;
      i_host.wr(ams_pkg::IDX_CONTROL, 8'h02, rr);
      for (int f = 0; f < 2; f++)
      begin
         fan_drive <= f[0];
         repeat (3) @(posedge aclk);
         chk("pin_out", {7'h0, f[0]}, {7'h0, shared_pin_out});
         chk("pin_oe", 8'h01, {7'h0, shared_pin_oe});
      end
      $display("fan test done");
   endtask : t_fan

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_mask1();
      t_mask2();
      t_chan();
      t_lock();
      t_fan();
      finish_test();
   end
endmodule : alert_mask_and_channel_select_test
